// ==== src/ingress_dev.sv ====
// Purpose: Device end: takes symbols, buffers them, feeds the link side.
// Assumes: Inputs synchronous to CLK_I; SYS_RST_I async, active high.
// Notes: Ready drops while a skid reserve of slots is still free.
//
// Operation
// - Start flags 1/2/4 bits, segment 3 at top
// - User flags a packet start per symbol
// - Top start bit marks first chunk start
// - At most one low start bit set
// - Word bus carries one symbol of 64-bit words
// - Bus width is words times sixty-four
// - First word sits in uppermost slice
// - Calendar input is N pages of 16
// - Calendar pages copied into control words
// - Page count is 1, 2, 4, 8 or 16
// - Calendar sampled apart from data handshake
// - Ready high means user may send
// - User stops within four cycles of ready low
// - Nonzero count only after ready high
// - End code: none, error, or byte count
// - Final word valid bytes start at top
`timescale 1ns/10ps
module sym_fifo #(
  parameter int W = 8,
  parameter int DEPTH = ingress_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk_i,                  // Clock
  input wire logic rst_i,                  // Async reset, high
  input wire logic in_valid_i,             // Write request
  output logic in_ready_o,                 // Room for a word
  input wire logic [W-1:0] in_data_i,      // Write data
  output logic out_valid_o,                // Word available
  input wire logic out_ready_i,            // Drain request
  output logic [W-1:0] out_data_o,         // Head word
  output logic [$clog2(DEPTH):0] count_o   // Words held
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rd_q];
  assign count_o = cnt_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage carries no reset; only the pointers and count define what is valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
endmodule

module ingress_dev #(
  parameter int WORDS = ingress_pkg::WORDS_DEF,
  parameter int SEGS = ingress_pkg::SEGS_DEF,
  parameter int PAGES = ingress_pkg::PAGES_DEF,
  parameter int DEPTH = ingress_pkg::FIFO_DEPTH_DEF
) (
  input wire logic CLK_I,                                 // 20 MHz clock
  input wire logic SYS_RST_I,                             // Async reset
  seg_tx_if.dev LINK,                                     // User side link
  output logic LNK_VALID_O,                               // Symbol ready
  input wire logic LNK_READY_I,                           // Link drains
  output logic [WORDS*ingress_pkg::WORD_W-1:0] LNK_WORDS_O, // Symbol
  output logic [SEGS-1:0] LNK_SOP_O,                      // Start flags
  output logic [ingress_pkg::CHUNKS*ingress_pkg::EOP_W-1:0] LNK_EOP_O,
  output logic [ingress_pkg::NUMV_W-1:0] LNK_NUMV_O,      // Word count
  input wire logic CW_REQ_I,                              // Control word
  output logic [ingress_pkg::PAGE_W-1:0] CW_FC_O,         // Page bits
  output logic CW_LAST_O,                                 // Last page
  output logic PROTO_ERR_O                                // Bad flags
);
  // ****************************************
  // Symbol intake and buffering
  // ****************************************
  localparam int DW = WORDS*ingress_pkg::WORD_W;
  localparam int EW = ingress_pkg::CHUNKS*ingress_pkg::EOP_W;
  localparam int NW = ingress_pkg::NUMV_W;
  localparam int FW = DW + SEGS + EW + NW;
  localparam int CW = PAGES*ingress_pkg::PAGE_W;
  localparam int PW = (PAGES > 1) ? $clog2(PAGES) : 1;

  logic take;
  logic fifo_in_ready;
  logic [FW-1:0] fifo_out;
  logic [$clog2(DEPTH):0] fifo_cnt;
  logic ready_q, ready_d;

  // Words stay in bus order, first word uppermost
  assign take = (LINK.num_valid != ingress_pkg::NUMV_ZERO)
    && ready_q && fifo_in_ready;
  assign LINK.ready = ready_q;

  sym_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(take),
    .in_ready_o(fifo_in_ready),
    .in_data_i({LINK.din_words, LINK.sop, LINK.eopbits, LINK.num_valid}),
    .out_valid_o(LNK_VALID_O),
    .out_ready_i(LNK_READY_I),
    .out_data_o(fifo_out),
    .count_o(fifo_cnt)
  );

  assign {LNK_WORDS_O, LNK_SOP_O, LNK_EOP_O, LNK_NUMV_O} = fifo_out;

  // Ready falls once fewer than four slots are free, and nothing is taken
  // while it is low, so the buffer never overflows
  always_comb begin
    ready_d = (int'(fifo_cnt) + (take ? 1 : 0)
      + ingress_pkg::SKID_SLOTS) <= DEPTH;
  end

  // ****************************************
  // Flag checks
  // ****************************************
  function automatic logic eop_bad(input logic [3:0] e);
    eop_bad = !e[ingress_pkg::EOP_END_BIT]
      && (e != ingress_pkg::EOP_NONE) && (e != ingress_pkg::EOP_ERR);
  endfunction

  logic err_q, err_d;
  logic [SEGS-1:0] low_sop;

  always_comb begin
    low_sop = LINK.sop;
    if (SEGS > 1) begin
      low_sop[SEGS-1] = 1'b0;
    end
    err_d = 1'b0;
    if (take) begin
      err_d = ($countones(low_sop) > 1)
        || eop_bad(LINK.eopbits[EW-1 -: 4])
        || eop_bad(LINK.eopbits[3:0]);
    end
  end
  assign PROTO_ERR_O = err_q;

  // ****************************************
  // Calendar to control words
  // ****************************************
  logic [CW-1:0] cal_q, cal_d;
  logic [PW-1:0] page_q, page_d;
  logic [ingress_pkg::PAGE_W-1:0] fc_q, fc_d;
  logic last_q, last_d;

  always_comb begin
    cal_d = LINK.calendar;
    page_d = page_q;
    fc_d = fc_q;
    last_d = last_q;
    if (CW_REQ_I) begin
      fc_d = cal_q[(PAGES-1-int'(page_q))*ingress_pkg::PAGE_W +:
        ingress_pkg::PAGE_W];
      last_d = (int'(page_q) == PAGES-1);
      page_d = (int'(page_q) == PAGES-1) ? '0 : page_q + 1'b1;
    end
  end
  assign CW_FC_O = fc_q;
  assign CW_LAST_O = last_q;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      cal_q <= '0;
      page_q <= '0;
      fc_q <= '0;
      last_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      err_q <= err_d;
      cal_q <= cal_d;
      page_q <= page_d;
      fc_q <= fc_d;
      last_q <= last_d;
    end
  end
endmodule

// ==== pkg/ingress_pkg.sv ====
// Purpose: Shared constants for the segmented transmit user ingress.
// Assumes: One 20 MHz clock for both ends.
// Notes: Widths that may differ per build are module parameters.
package ingress_pkg;
  // ****************************************
  // Bus geometry defaults
  // ****************************************
  localparam int WORD_W = 64;
  localparam int WORDS_DEF = 8;
  localparam int SEGS_DEF = 4;
  localparam int PAGES_DEF = 1;
  localparam int PAGE_W = 16;
  localparam int NUMV_W = 5;
  localparam int EOP_W = 4;
  localparam int CHUNKS = 2;
  // ****************************************
  // Flow control and buffering
  // ****************************************
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int SKID_SLOTS = 4;
  // ****************************************
  // Packet end codes
  // ****************************************
  localparam logic [3:0] EOP_NONE = 4'h0;
  localparam logic [3:0] EOP_ERR = 4'h1;
  localparam int EOP_END_BIT = 3;
  localparam logic [4:0] NUMV_ZERO = 5'h00;
endpackage

// ==== pkg/seg_tx_if.sv ====
// Purpose: Link between the user packet source and the ingress.
// Assumes: Both ends share CLK_I; no tristate pins.
// Notes: The testbench supplies clk and rst.
`timescale 1ns/10ps
interface seg_tx_if #(
  parameter int WORDS = ingress_pkg::WORDS_DEF,
  parameter int SEGS = ingress_pkg::SEGS_DEF,
  parameter int PAGES = ingress_pkg::PAGES_DEF
) (
  input wire logic clk,
  input wire logic rst
);
  logic [WORDS*ingress_pkg::WORD_W-1:0] din_words;
  logic [SEGS-1:0] sop;
  logic [ingress_pkg::CHUNKS*ingress_pkg::EOP_W-1:0] eopbits;
  logic [ingress_pkg::NUMV_W-1:0] num_valid;
  logic [PAGES*ingress_pkg::PAGE_W-1:0] calendar;
  logic ready;

  modport dev (
    input clk, rst, din_words, sop, eopbits, num_valid, calendar,
    output ready
  );
  modport src (
    input clk, rst, ready,
    output din_words, sop, eopbits, num_valid, calendar
  );
endinterface

// ==== src/ingress_src.sv ====
// Purpose: User end: holds one symbol and offers it to the ingress.
// Assumes: Inputs synchronous to CLK_I; SYS_RST_I async, active high.
// Notes: User words arrive with word 0 in the lowest slice.
`timescale 1ns/10ps
module ingress_src #(
  parameter int WORDS = ingress_pkg::WORDS_DEF,
  parameter int SEGS = ingress_pkg::SEGS_DEF,
  parameter int PAGES = ingress_pkg::PAGES_DEF
) (
  input wire logic CLK_I,                                 // 20 MHz clock
  input wire logic SYS_RST_I,                             // Async reset
  seg_tx_if.src LINK,                                     // Link to device
  input wire logic USR_VALID_I,                           // Symbol offered
  output logic USR_READY_O,                               // Symbol taken
  input wire logic [WORDS*ingress_pkg::WORD_W-1:0] USR_WORDS_I, // Words
  input wire logic [SEGS-1:0] USR_SOP_I,                  // Start flags
  input wire logic [ingress_pkg::CHUNKS*ingress_pkg::EOP_W-1:0] USR_EOP_I,
  input wire logic [ingress_pkg::NUMV_W-1:0] USR_NUMV_I,  // Word count
  input wire logic [PAGES*ingress_pkg::PAGE_W-1:0] USR_CAL_I // Calendar
);
  // ****************************************
  // Word order and holding register
  // ****************************************
  localparam int WW = ingress_pkg::WORD_W;
  localparam int DW = WORDS*WW;

  function automatic logic [DW-1:0] to_bus(input logic [DW-1:0] w);
    to_bus = '0;
    for (int i = 0; i < WORDS; i++) begin
      to_bus[(WORDS-1-i)*WW +: WW] = w[i*WW +: WW];
    end
  endfunction

  logic hold_q, hold_d;
  logic [DW-1:0] words_q, words_d;
  logic [SEGS-1:0] sop_q, sop_d;
  logic [ingress_pkg::CHUNKS*ingress_pkg::EOP_W-1:0] eop_q, eop_d;
  logic [ingress_pkg::NUMV_W-1:0] numv_q, numv_d;
  logic [PAGES*ingress_pkg::PAGE_W-1:0] cal_q, cal_d;
  logic taken;

  // Count shows only while ready is high, so it stops the same cycle
  assign LINK.num_valid = (hold_q && LINK.ready) ? numv_q
    : ingress_pkg::NUMV_ZERO;
  assign taken = hold_q && LINK.ready;
  assign USR_READY_O = !hold_q || taken;
  assign LINK.din_words = words_q;
  assign LINK.sop = sop_q;
  assign LINK.eopbits = eop_q;
  assign LINK.calendar = cal_q;

  always_comb begin
    hold_d = hold_q;
    words_d = words_q;
    sop_d = sop_q;
    eop_d = eop_q;
    numv_d = numv_q;
    cal_d = USR_CAL_I;
    if (taken) begin
      hold_d = 1'b0;
    end
    if (USR_VALID_I && USR_READY_O
        && (USR_NUMV_I != ingress_pkg::NUMV_ZERO)) begin
      hold_d = 1'b1;
      words_d = to_bus(USR_WORDS_I);
      sop_d = USR_SOP_I;
      if (SEGS > 2 && $countones(USR_SOP_I[SEGS-2:0]) > 1) begin
        sop_d[SEGS-2:0] = '0;
      end
      eop_d = USR_EOP_I;
      numv_d = USR_NUMV_I;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      hold_q <= 1'b0;
      words_q <= '0;
      sop_q <= '0;
      eop_q <= '0;
      numv_q <= '0;
      cal_q <= '0;
    end else begin
      hold_q <= hold_d;
      words_q <= words_d;
      sop_q <= sop_d;
      eop_q <= eop_d;
      numv_q <= numv_d;
      cal_q <= cal_d;
    end
  end
endmodule

// ==== bench/ingress_props.sv ====
// Purpose: Protocol checks on the source-to-ingress link.
// Assumes: One clock; rst asynchronous, active high.
// Notes: Sees interface signals only.
`timescale 1ns/10ps
module ingress_props #(
  parameter int WORDS = ingress_pkg::WORDS_DEF,
  parameter int SEGS = ingress_pkg::SEGS_DEF
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [SEGS-1:0] sop, // Start flags
  input wire logic [7:0] eopbits, // End codes
  input wire logic [4:0] num_valid, // Word count
  input wire logic ready // Back-pressure
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_nv_ready;
    num_valid != 5'h00 |-> ready;
  endproperty
  a_nv_ready: assert property (p_nv_ready)
    else $error("count offered while not ready");
  property p_idle_start;
    $fell(rst) |-> num_valid == 5'h00 && !ready;
  endproperty
  a_idle_start: assert property (p_idle_start)
    else $error("link busy at reset release");
  property p_ready_up;
    $fell(rst) |-> ##[0:2] ready;
  endproperty
  a_ready_up: assert property (p_ready_up)
    else $error("ready late after reset");
  property p_fall_cause;
    $fell(ready) |-> $past(num_valid) != 5'h00;
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("ready fell without a take");
  property p_keep_ready;
    ready && num_valid == 5'h00 |=> ready;
  endproperty
  a_keep_ready: assert property (p_keep_ready)
    else $error("ready fell while idle");
  property p_sop_one;
    num_valid != 5'h00 |-> $countones(sop[SEGS-2:0]) <= 1;
  endproperty
  a_sop_one: assert property (p_sop_one)
    else $error("several low start flags");
  property p_eop_ok;
    num_valid != 5'h00 |-> eopbits[7:6] != 2'b01 && eopbits[7:5] != 3'b001
      && eopbits[3:2] != 2'b01 && eopbits[3:1] != 3'b001;
  endproperty
  a_eop_ok: assert property (p_eop_ok)
    else $error("undefined end code");
  property p_nv_range;
    num_valid != 5'h00 |-> num_valid <= WORDS;
  endproperty
  a_nv_range: assert property (p_nv_range)
    else $error("count above symbol size");
endmodule

// ==== bench/segmented_tx_user_ingress_test.sv ====
// Purpose: Self-checking bench for source and ingress ends.
// Assumes: 20 MHz clock, PAGES=2, FIFO depth 8.
// Notes: Stalls the link side until ready drops with five of eight FIFO slots used.
`timescale 1ns/10ps
module segmented_tx_user_ingress_test;
  localparam int WORDS = 8;
  localparam int SW = WORDS * 64;
  localparam int SEGS = 4;
  localparam int PAGES = 2;
  localparam int DEPTH = 8;
  logic clk, rst, usr_valid, usr_ready, lnk_valid, lnk_ready;
  logic cw_req, cw_last, proto_err;
  logic [SW-1:0] usr_words, lnk_words;
  logic [3:0] usr_sop, lnk_sop;
  logic [7:0] usr_eop, lnk_eop;
  logic [4:0] usr_numv, lnk_numv;
  logic [31:0] usr_cal;
  logic [15:0] cw_fc;
  logic [7:0] eop_tab [4] = '{8'h00, 8'h01, 8'h80, 8'h9f};
  int failures, cmp_count, k;
  always #25 clk = ~clk;
  seg_tx_if #(.WORDS(WORDS), .SEGS(SEGS), .PAGES(PAGES)) link_if (
    .clk(clk), .rst(rst));
  ingress_src #(.WORDS(WORDS), .SEGS(SEGS), .PAGES(PAGES)) ingress_src_i (
    .CLK_I(clk), .SYS_RST_I(rst), .LINK(link_if.src),
    .USR_VALID_I(usr_valid), .USR_READY_O(usr_ready),
    .USR_WORDS_I(usr_words), .USR_SOP_I(usr_sop), .USR_EOP_I(usr_eop),
    .USR_NUMV_I(usr_numv), .USR_CAL_I(usr_cal));
  ingress_dev #(.WORDS(WORDS), .SEGS(SEGS), .PAGES(PAGES), .DEPTH(DEPTH))
    ingress_dev_i (
    .CLK_I(clk), .SYS_RST_I(rst), .LINK(link_if.dev),
    .LNK_VALID_O(lnk_valid), .LNK_READY_I(lnk_ready),
    .LNK_WORDS_O(lnk_words), .LNK_SOP_O(lnk_sop), .LNK_EOP_O(lnk_eop),
    .LNK_NUMV_O(lnk_numv), .CW_REQ_I(cw_req), .CW_FC_O(cw_fc),
    .CW_LAST_O(cw_last), .PROTO_ERR_O(proto_err));
  ingress_props #(.WORDS(WORDS), .SEGS(SEGS)) ingress_props_i (
    .clk(link_if.clk), .rst(link_if.rst), .sop(link_if.sop),
    .eopbits(link_if.eopbits), .num_valid(link_if.num_valid),
    .ready(link_if.ready));
  // ****************************************
  // Tasks
  // ****************************************
  // Word i of symbol k; rev puts word 0 in the top slice
  function automatic logic [SW-1:0] sym(input int k, input bit rev);
    logic [SW-1:0] v;
    for (int i = 0; i < WORDS; i++) begin
      v[(rev ? WORDS-1-i : i)*64 +: 64] = 64'h5a00_0000_0000_0000 +
        64'(k * 256 + i);
    end
    return v;
  endfunction
  task automatic chk(input logic [SW-1:0] seen, input logic [SW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Holds valid up on return so back-to-back calls never toggle it
  task automatic send(input int k, input logic [4:0] nv, input logic [3:0] s);
    int n;
    usr_words <= sym(k, 1'b0);
    usr_sop <= s;
    usr_eop <= eop_tab[k%4];
    usr_numv <= nv;
    usr_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (usr_ready !== 1'b1 && n < 40);
    @(posedge clk);
  endtask
  task automatic pop(input int k, input logic [4:0] nv, input logic [3:0] s);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lnk_valid !== 1'b1 && n < 40);
    chk(lnk_words, sym(k, 1'b1));
    chk(SW'(lnk_sop), SW'(s));
    chk(SW'(lnk_eop), SW'(eop_tab[k%4]));
    chk(SW'(lnk_numv), SW'(nv));
    @(posedge clk);
    lnk_ready <= 1'b1;
    @(posedge clk);
    lnk_ready <= 1'b0;
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clk = 0; rst = 1; usr_valid = 0; usr_words = '0; usr_sop = '0;
    usr_eop = '0; usr_numv = '0; usr_cal = '0; lnk_ready = 0; cw_req = 0;
    failures = 0; cmp_count = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    send(9, 5'h00, 4'h8);
    usr_valid <= 1'b0;
    repeat (3) @(negedge clk);
    chk(SW'(lnk_valid), SW'(0));
    @(posedge clk);
    for (k = 0; k < 6; k++) send(k, 5'(WORDS - k), 4'h8 >> (k % 4));
    usr_valid <= 1'b0;
    @(negedge clk);
    chk(SW'(link_if.ready), SW'(0));
    chk(SW'(usr_ready), SW'(0));
    chk(SW'(link_if.num_valid), SW'(0));
    chk(link_if.din_words, sym(5, 1'b1));
    for (k = 0; k < 6; k++) pop(k, 5'(WORDS - k), 4'h8 >> (k % 4));
    repeat (2) @(negedge clk);
    chk(SW'(lnk_valid), SW'(0));
    chk(SW'(link_if.ready), SW'(1));
    @(posedge clk);
    send(3, 5'h01, 4'hb);
    usr_valid <= 1'b0;
    pop(3, 5'h01, 4'h8);
    usr_cal <= 32'h1234_5678;
    repeat (3) @(posedge clk);
    for (k = 0; k < 2; k++) begin
      cw_req <= 1'b1;
      @(posedge clk);
      cw_req <= 1'b0;
      @(negedge clk);
      chk(SW'(cw_fc), SW'(k == 0 ? 16'h1234 : 16'h5678));
      chk(SW'(cw_last), SW'(k));
      @(posedge clk);
    end
    close_out;
  end
  // Source filters bad start flags, so the ingress must never flag one
  always @(negedge clk) begin
    chk(SW'(proto_err), SW'(0));
  end
  // Whole run needs well under 400 cycles
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    $display("Error at %0t: timeout", $time);
    close_out;
  end
endmodule
